// File: inc/dac_cmd_pkg.sv
// Shared constants for the dual converter serial command decoder.
package dac_cmd_pkg;

	// ****************************************
	// Word layout
	// ****************************************
	localparam int WORD_W   = 16; // Bits in one serial word.
	localparam int DATA_W   = 12; // Bits of converter data.
	localparam int ADDR_POS = 15; // Channel address bit, sent first.
	localparam int CTL_HI   = 14; // Upper control bit.
	localparam int CTL_LO   = 13; // Lower control bit.
	localparam int DATA_MSB = 12; // Top data bit.
	localparam int DATA_LSB = 1;  // Bottom data bit.
	localparam int SUB_POS  = 0;  // Trailing sub-bit, always zero.
	localparam int EXT_HI   = 11; // Extended code top, within the data field.
	localparam int EXT_LO   = 9;  // Extended code selector bottom.
	localparam int EXT_LSB  = 8;  // Extended code last bit.

	// ****************************************
	// Command encodings: address bit then control bits
	// ****************************************
	localparam logic [2:0] CMD_EXT      = 3'h0;
	localparam logic [2:0] CMD_LD_IN_A  = 3'h1;
	localparam logic [2:0] CMD_UPD_A    = 3'h2;
	localparam logic [2:0] CMD_DIRECT   = 3'h3;
	localparam logic [2:0] CMD_RECALL   = 3'h4;
	localparam logic [2:0] CMD_LD_IN_B  = 3'h5;
	localparam logic [2:0] CMD_UPD_B    = 3'h6;
	localparam logic [2:0] CMD_PD_BOTH  = 3'h7;

	// ****************************************
	// Extended codes (top three bits of the data field)
	// ****************************************
	localparam logic [2:0] EXT_NOP      = 3'h0;
	localparam logic [2:0] EXT_RECALL_A = 3'h1;
	localparam logic [2:0] EXT_UPO_LO   = 3'h2;
	localparam logic [2:0] EXT_UPO_HI   = 3'h3;
	localparam logic [2:0] EXT_MODE     = 3'h4;
	localparam logic [2:0] EXT_RECALL_B = 3'h5;
	localparam logic [2:0] EXT_PD_A     = 3'h6;
	localparam logic [2:0] EXT_PD_B     = 3'h7;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [11:0] DAC_RST  = 12'h000; // Registers clear to zero.
	localparam logic        UPO_RST  = 1'h0;    // User output starts low.
	localparam logic        MODE_RST = 1'h0;    // Falling-edge output mode.
	localparam logic        PD_RST   = 1'h0;    // Channels start awake.

endpackage

// File: hdl/bit_sync.sv
// Two flip-flop level synchroniser.
`timescale 1ns/1ps
module bit_sync #(
	parameter logic RST_VAL = 1'h0
) (
	input  wire logic clk_i,  // Destination clock.
	input  wire logic nrst_i, // Asynchronous reset, active low.
	input  wire logic d_i,    // Level from another domain.
	output logic      q_o     // Synchronised level.
);
	logic meta_r; // First stage, read only by the second stage.

	// ****************************************
	// Two-stage chain
	// ****************************************
	// The first stage may go metastable, so only the second stage reads it.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_r <= RST_VAL;
			q_o    <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule // bit_sync

// File: hdl/link_shifter.sv
// Serial-clock domain shift register and data-out stage.
`timescale 1ns/1ps
module link_shifter (
	input  wire logic        sclk_i,      // Serial clock from the host.
	input  wire logic        nrst_i,      // Asynchronous reset, active low.
	input  wire logic        cs_n_i,      // Chip select, active low.
	input  wire logic        din_i,       // Serial data in.
	input  wire logic        mode_rise_i, // Rising-edge output mode, system domain.
	output logic [15:0]      shift_o,     // Shift register contents.
	output logic             dout_o       // Serial data out.
);
	logic mode_s;    // Output mode seen in the serial domain.
	logic dout_f_r;  // Falling-edge output stage.
	logic dout_r_r;  // Rising-edge output stage.

	// The mode only changes between frames; the first edges of a frame may
	// still use the old mode, since this clock stands still between frames.
	bit_sync #(.RST_VAL(dac_cmd_pkg::MODE_RST)) u_mode_sync (
		.clk_i  (sclk_i),
		.nrst_i (nrst_i),
		.d_i    (mode_rise_i),
		.q_o    (mode_s)
	);

	// ****************************************
	// Shift register
	// ****************************************
	// Data is taken on each rising edge only inside a frame.
	always_ff @(posedge sclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shift_o <= 16'h0000;
		end else if (!cs_n_i) begin
			shift_o <= {shift_o[14:0], din_i};
		end
	end

	// Rising-edge output copy of the bit that becomes the top of the register
	// at this edge. This shows it half a cycle before the falling-edge stage.
	// Taking the old top bit instead would add a whole extra cycle of lag.
	always_ff @(posedge sclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dout_r_r <= 1'h0;
		end else if (!cs_n_i) begin
			dout_r_r <= shift_o[14];
		end
	end

	// Falling-edge output copy of the bit leaving the register.
	always_ff @(negedge sclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dout_f_r <= 1'h0;
		end else begin
			dout_f_r <= shift_o[15];
		end
	end

	// Both stages are flops; the mode only picks which one reaches the pin.
	assign dout_o = mode_s ? dout_r_r : dout_f_r;
endmodule // link_shifter

// File: hdl/dual_dac_serial_command_decoder.sv
// Command decoder for a dual 12-bit converter on a three-wire serial link.
`timescale 1ns/1ps
// Function
// - One shift register, two input/DAC register pairs.
// - Word: address, two controls, twelve data, sub-bit.
// - Control 01 loads chosen input register only.
// - Control 10 loads input, then updates both DACs.
// - Address 0, control 11 loads both DACs.
// - Address 1, control 00 recalls both, wakes both.
// - Address 1, control 11 shuts both if allowed.
// - All-zero header makes top data bits extended.
// - Extended 001x/101x recall and wake one channel.
// - Extended 110x/111x shut one channel if allowed.
// - Extended 010x/011x drive user output low/high.
// - Extended 1001 rising, 1000 falling output mode.
// - Link keeps decoding while channels are down.
// - Shutdown leaves input registers untouched.
// - Refreshing a DAC register wakes that channel.
// - Sample data on rising clock in frame.
// - Chip select rising commits the decoded word.
// - Data out lags 15 or 15.5 cycles.
// - Lockout falling edge wakes shut channels.
module dual_dac_serial_command_decoder (
	input  wire logic        clk_sys_i,            // System clock, 125 MHz.
	input  wire logic        nrst_i,               // Power-on reset, active low.
	input  wire logic        clear_n_i,            // Clear input, active low.
	input  wire logic        sclk_i,               // Serial clock from host.
	input  wire logic        cs_n_i,               // Chip select, active low.
	input  wire logic        din_i,                // Serial data in.
	input  wire logic        shutdown_lockout_n_i, // Low forbids shutdown.
	output logic             dout_o,               // Serial data out.
	output logic [11:0]      input_a_o,            // Input register A.
	output logic [11:0]      input_b_o,            // Input register B.
	output logic [11:0]      dac_a_o,              // DAC register A.
	output logic [11:0]      dac_b_o,              // DAC register B.
	output logic             pd_a_o,               // Channel A powered down.
	output logic             pd_b_o,               // Channel B powered down.
	output logic             user_logic_output_o,  // User logic output.
	output logic             mode_rise_o           // High: data out on rising edge.
);

	// ****************************************
	// Reset and crossings
	// ****************************************
	logic        rst_n_w;     // Combined reset and clear.
	logic        cs_s;        // Chip select in the system domain.
	logic        cs_d_r;      // Chip select one cycle later.
	logic        lock_s;      // Lockout in the system domain.
	logic        lock_d_r;    // Lockout one cycle later.
	logic        frame_end;   // Chip select has just gone high.
	logic [15:0] shift_w;     // Shift register from the serial domain.
	logic [15:0] word_r;      // Captured command word.
	logic        cmd_v_r;     // One-cycle strobe: word_r holds a new command.

	// Clear acts like reset on every register of this domain.
	assign rst_n_w = nrst_i & clear_n_i;

	// Chip select resets high so no frame end is seen out of reset.
	bit_sync #(.RST_VAL(1'h1)) u_cs_sync (
		.clk_i  (clk_sys_i),
		.nrst_i (rst_n_w),
		.d_i    (cs_n_i),
		.q_o    (cs_s)
	);

	// Lockout resets high, the state that permits shutdown.
	bit_sync #(.RST_VAL(1'h1)) u_lock_sync (
		.clk_i  (clk_sys_i),
		.nrst_i (rst_n_w),
		.d_i    (shutdown_lockout_n_i),
		.q_o    (lock_s)
	);

	// The link logic runs on the serial clock only.
	link_shifter u_link (
		.sclk_i      (sclk_i),
		.nrst_i      (nrst_i),
		.cs_n_i      (cs_n_i),
		.din_i       (din_i),
		.mode_rise_i (mode_rise_o),
		.shift_o     (shift_w),
		.dout_o      (dout_o)
	);

	// Delayed copies for edge detection, taken from synchronised levels.
	always_ff @(posedge clk_sys_i or negedge rst_n_w) begin
		if (!rst_n_w) begin
			cs_d_r   <= 1'h1;
			lock_d_r <= 1'h1;
		end else begin
			cs_d_r   <= cs_s;
			lock_d_r <= lock_s;
		end
	end

	assign frame_end = cs_s & ~cs_d_r;

	// ****************************************
	// Word capture
	// ****************************************
	// With chip select high the serial clock cannot shift, so the word is
	// stable when the synchronised frame end arrives; this is the handshake.
	// Only the final sixteen bits remain in the register after long frames.
	always_ff @(posedge clk_sys_i or negedge rst_n_w) begin
		if (!rst_n_w) begin
			word_r  <= 16'h0000;
			cmd_v_r <= 1'h0;
		end else begin
			cmd_v_r <= frame_end;
			if (frame_end) begin
				word_r <= shift_w;
			end
		end
	end

	// ****************************************
	// Field decode
	// ****************************************
	logic [2:0]  hdr_w;   // Address bit and both control bits.
	logic [11:0] data_w;  // Data field.
	logic [2:0]  ext_w;   // Extended code selector.
	logic        ext0_w;  // Extended code last bit.

	// Pulls the data field out of a word; used for decode and checks.
	function automatic logic [11:0] data_of(input logic [15:0] w);
		data_of = w[dac_cmd_pkg::DATA_MSB:dac_cmd_pkg::DATA_LSB];
	endfunction

	// The sub-bit is ignored; the host keeps it zero.
	assign hdr_w  = {word_r[dac_cmd_pkg::ADDR_POS],
		word_r[dac_cmd_pkg::CTL_HI], word_r[dac_cmd_pkg::CTL_LO]};
	assign data_w = data_of(word_r);
	assign ext_w  = data_w[dac_cmd_pkg::EXT_HI:dac_cmd_pkg::EXT_LO];
	assign ext0_w = data_w[dac_cmd_pkg::EXT_LSB];

	// ****************************************
	// Command actions
	// ****************************************
	logic ld_in_a;   // Load input register A.
	logic ld_in_b;   // Load input register B.
	logic upd_a;     // DAC A takes from input path.
	logic upd_b;     // DAC B takes from input path.
	logic direct;    // Both DACs take the data field.
	logic pd_req_a;  // Shutdown request for A.
	logic pd_req_b;  // Shutdown request for B.
	logic upo_wr;    // Write the user output.
	logic upo_val;   // Value for the user output.
	logic mode_wr;   // Write the output mode.

	// Decoding runs whatever the power state, so shut channels still listen.
	always_comb begin
		ld_in_a  = 1'h0;
		ld_in_b  = 1'h0;
		upd_a    = 1'h0;
		upd_b    = 1'h0;
		direct   = 1'h0;
		pd_req_a = 1'h0;
		pd_req_b = 1'h0;
		upo_wr   = 1'h0;
		upo_val  = 1'h0;
		mode_wr  = 1'h0;
		if (cmd_v_r) begin
			case (hdr_w)
				dac_cmd_pkg::CMD_LD_IN_A: begin
					ld_in_a = 1'h1;
				end
				dac_cmd_pkg::CMD_LD_IN_B: begin
					ld_in_b = 1'h1;
				end
				dac_cmd_pkg::CMD_UPD_A: begin
					ld_in_a = 1'h1;
					upd_a   = 1'h1;
					upd_b   = 1'h1;
				end
				dac_cmd_pkg::CMD_UPD_B: begin
					ld_in_b = 1'h1;
					upd_a   = 1'h1;
					upd_b   = 1'h1;
				end
				dac_cmd_pkg::CMD_DIRECT: begin
					direct = 1'h1;
				end
				dac_cmd_pkg::CMD_RECALL: begin
					upd_a = 1'h1;
					upd_b = 1'h1;
				end
				dac_cmd_pkg::CMD_PD_BOTH: begin
					pd_req_a = 1'h1;
					pd_req_b = 1'h1;
				end
				dac_cmd_pkg::CMD_EXT: begin
					// The top data bits become the command here.
					case (ext_w)
						dac_cmd_pkg::EXT_RECALL_A: upd_a = 1'h1;
						dac_cmd_pkg::EXT_RECALL_B: upd_b = 1'h1;
						dac_cmd_pkg::EXT_PD_A: pd_req_a = 1'h1;
						dac_cmd_pkg::EXT_PD_B: pd_req_b = 1'h1;
						dac_cmd_pkg::EXT_UPO_LO: begin
							upo_wr  = 1'h1;
							upo_val = 1'h0;
						end
						dac_cmd_pkg::EXT_UPO_HI: begin
							upo_wr  = 1'h1;
							upo_val = 1'h1;
						end
						dac_cmd_pkg::EXT_MODE: mode_wr = 1'h1;
						default: begin
							// No operation leaves every register as it is.
							upo_wr = 1'h0;
						end
					endcase
				end
				default: begin
					upo_wr = 1'h0;
				end
			endcase
		end
	end

	// ****************************************
	// Input registers
	// ****************************************
	// Shutdown never writes these, so a recall restores the old value.
	always_ff @(posedge clk_sys_i or negedge rst_n_w) begin
		if (!rst_n_w) begin
			input_a_o <= dac_cmd_pkg::DAC_RST;
			input_b_o <= dac_cmd_pkg::DAC_RST;
		end else begin
			if (ld_in_a) begin
				input_a_o <= data_w;
			end
			if (ld_in_b) begin
				input_b_o <= data_w;
			end
		end
	end

	// ****************************************
	// DAC registers
	// ****************************************
	// An update takes the freshly loaded data when the same word loaded the
	// input register, so the transfer follows the load.
	always_ff @(posedge clk_sys_i or negedge rst_n_w) begin
		if (!rst_n_w) begin
			dac_a_o <= dac_cmd_pkg::DAC_RST;
			dac_b_o <= dac_cmd_pkg::DAC_RST;
		end else begin
			if (direct) begin
				dac_a_o <= data_w;
			end else if (upd_a) begin
				dac_a_o <= ld_in_a ? data_w : input_a_o;
			end
			if (direct) begin
				dac_b_o <= data_w;
			end else if (upd_b) begin
				dac_b_o <= ld_in_b ? data_w : input_b_o;
			end
		end
	end

	// ****************************************
	// Power state
	// ****************************************
	// A refresh wins over a shutdown; a low lockout blocks shutdown and its
	// falling edge wakes both channels. The wake is seen after the two-flop
	// synchroniser, a few system clocks after the pin moves.
	always_ff @(posedge clk_sys_i or negedge rst_n_w) begin
		if (!rst_n_w) begin
			pd_a_o <= dac_cmd_pkg::PD_RST;
			pd_b_o <= dac_cmd_pkg::PD_RST;
		end else begin
			if (direct || upd_a) begin
				pd_a_o <= 1'h0;
			end else if (pd_req_a && lock_s) begin
				pd_a_o <= 1'h1;
			end else if (lock_d_r && !lock_s) begin
				pd_a_o <= 1'h0;
			end
			if (direct || upd_b) begin
				pd_b_o <= 1'h0;
			end else if (pd_req_b && lock_s) begin
				pd_b_o <= 1'h1;
			end else if (lock_d_r && !lock_s) begin
				pd_b_o <= 1'h0;
			end
		end
	end

	// ****************************************
	// User output and data-out mode
	// ****************************************
	// Both return to their defaults on clear or reset.
	always_ff @(posedge clk_sys_i or negedge rst_n_w) begin
		if (!rst_n_w) begin
			user_logic_output_o <= dac_cmd_pkg::UPO_RST;
			mode_rise_o         <= dac_cmd_pkg::MODE_RST;
		end else begin
			if (upo_wr) begin
				user_logic_output_o <= upo_val;
			end
			if (mode_wr) begin
				mode_rise_o <= ext0_w;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_w);

	a_frame_capture: assert property (frame_end |=> cmd_v_r && word_r == $past(shift_w))
		else $error("word not captured at frame end");
	a_load_input: assert property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_LD_IN_A
		|=> input_a_o == $past(data_w) && $stable(dac_a_o) && $stable(dac_b_o))
		else $error("input load touched a DAC register");
	a_load_update: assert property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_UPD_B
		|=> dac_b_o == $past(data_w) && dac_a_o == $past(input_a_o))
		else $error("load and update went wrong");
	a_direct_load: assert property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_DIRECT
		|=> dac_a_o == $past(data_w) && dac_b_o == $past(data_w) && !pd_a_o && !pd_b_o)
		else $error("direct load went wrong");
	a_recall_both: assert property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_RECALL
		|=> dac_a_o == $past(input_a_o) && dac_b_o == $past(input_b_o) && !pd_b_o)
		else $error("recall did not restore both");
	a_shutdown_gate: assert property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_PD_BOTH
		|=> (pd_a_o && pd_b_o) == $past(lock_s))
		else $error("shutdown ignored the lockout");
	a_ext_recall: assert property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_EXT
		&& ext_w == dac_cmd_pkg::EXT_RECALL_A
		|=> dac_a_o == $past(input_a_o) && !pd_a_o && $stable(dac_b_o))
		else $error("single recall went wrong");
	a_ext_shutdown: assert property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_EXT
		&& ext_w == dac_cmd_pkg::EXT_PD_B && lock_s |=> pd_b_o && $stable(pd_a_o))
		else $error("single shutdown went wrong");
	a_user_output: assert property (upo_wr |=> user_logic_output_o == $past(ext_w[0]))
		else $error("user output value wrong");
	a_mode_select: assert property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_EXT
		&& ext_w == dac_cmd_pkg::EXT_MODE |=> mode_rise_o == $past(ext0_w))
		else $error("output mode not set");
	a_nop_stable: assert property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_EXT
		&& ext_w == dac_cmd_pkg::EXT_NOP |=> $stable(dac_a_o) && $stable(input_b_o)
		&& $stable(user_logic_output_o) && $stable(mode_rise_o) && $stable(pd_a_o))
		else $error("no-operation changed state");
	a_pd_keeps_input: assert property ($rose(pd_a_o) |-> $stable(input_a_o))
		else $error("shutdown changed an input register");
	a_lock_wake: assert property (lock_d_r && !lock_s |=> !pd_a_o && !pd_b_o)
		else $error("lockout edge did not wake");

	c_direct: cover property (cmd_v_r && hdr_w == dac_cmd_pkg::CMD_DIRECT);
	c_shutdown: cover property (pd_a_o && pd_b_o ##[1:1000] cmd_v_r ##1 !pd_a_o);
	c_mode_rise: cover property ($rose(mode_rise_o));
	c_lock_wake: cover property (pd_b_o && lock_d_r && !lock_s);

endmodule // dual_dac_serial_command_decoder

// File: test/host_link_model.sv
// Host-side serial master model that drives the three-wire link.
`timescale 1ns/1ps
module host_link_model (
	input  wire logic dout_i, // Serial data coming back from the device.
	output logic      sclk_o, // Serial clock, parked low between frames.
	output logic      cs_n_o, // Chip select, active low.
	output logic      din_o   // Serial data to the device.
);
	// Idle levels: clock still, select high.
	initial begin
		sclk_o = 1'h0;
		cs_n_o = 1'h1;
		din_o  = 1'h0;
	end

	// ****************************************
	// One frame of pre filler bits, then the word MSB first
	// ****************************************
	// The data-out value is taken just before each rising edge, so rx
	// ends up holding the last sixteen bits that the device shifted out.
	task automatic send(input logic [15:0] w, input int pre, output logic [15:0] rx);
		rx = 16'h0000;
		cs_n_o = 1'h0;
		#40;
		for (int i = 0; i < pre + 16; i++) begin
			din_o = (i < pre) ? i[0] : w[15 - (i - pre)];
			#7 rx = {rx[14:0], dout_i};
			#8 sclk_o = 1'h1;
			#15 sclk_o = 1'h0;
		end
		#40 cs_n_o = 1'h1;
		// Data is no longer held: show the opposite level, not the stale one.
		din_o = ~din_o;
		#100;
	endtask
endmodule // host_link_model

// File: test/testbench.sv
// Self-checking bench for the dual converter serial command decoder.
`timescale 1ns/1ps
module testbench;
	logic        clk_sys_i, nrst_i, clear_n_i, lock_n; // Bench-driven inputs.
	logic        sclk, cs_n, din, dout;                // Serial link wires.
	logic [11:0] in_a, in_b, dac_a, dac_b;             // Register outputs.
	logic        pd_a, pd_b, user_logic_output, mode_r;              // Flag outputs.
	logic [11:0] ea, eb, qa, qb;                       // Expected registers.
	logic        epa, epb, eupo, emode;                // Expected flags.
	logic [15:0] rx, w;                                // Readback and word.
	logic [31:0] r;                                    // Random draw.
	int          err_total, checks_done, cycles;       // Counters.
	int          seed = 53568;                         // Fixed random seed.

	dual_dac_serial_command_decoder dual_dac_serial_command_decoder_i (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clear_n_i(clear_n_i),
		.sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .shutdown_lockout_n_i(lock_n),
		.dout_o(dout), .input_a_o(in_a), .input_b_o(in_b), .dac_a_o(dac_a),
		.dac_b_o(dac_b), .pd_a_o(pd_a), .pd_b_o(pd_b),
		.user_logic_output_o(user_logic_output), .mode_rise_o(mode_r));
	host_link_model host_link_model_i (.dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

	// 125 MHz system clock.
	initial begin
		clk_sys_i = 1'h0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// Hang guard: far above the roughly ten thousand cycles the run needs.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// Compare every register and flag output (all but data out) against the expectation.
	task automatic check_all();
		cmp16({4'h0, in_a}, {4'h0, ea}, "input a");
		cmp16({4'h0, in_b}, {4'h0, eb}, "input b");
		cmp16({4'h0, dac_a}, {4'h0, qa}, "dac a");
		cmp16({4'h0, dac_b}, {4'h0, qb}, "dac b");
		cmp1(pd_a, epa, "shutdown a");
		cmp1(pd_b, epb, "shutdown b");
		cmp1(user_logic_output, eupo, "user output");
		cmp1(mode_r, emode, "edge mode");
	endtask

	// Clear or power-on reset returns every register and flag output to zero.
	task automatic rst_exp();
		ea = 12'h000; eb = 12'h000; qa = 12'h000; qb = 12'h000;
		epa = 1'h0; epb = 1'h0; eupo = 1'h0; emode = 1'h0;
	endtask

	// ****************************************
	// Reference decode of one word
	// ****************************************
	function automatic void predict(input logic [15:0] wd);
		logic [11:0] d;
		d = wd[12:1];
		case (wd[15:13])
			3'h1: ea = d;
			3'h5: eb = d;
			3'h2: begin ea = d; qa = d; qb = eb; epa = 0; epb = 0; end
			3'h6: begin eb = d; qa = ea; qb = d; epa = 0; epb = 0; end
			3'h3: begin qa = d; qb = d; epa = 0; epb = 0; end
			3'h4: begin qa = ea; qb = eb; epa = 0; epb = 0; end
			3'h7: if (lock_n) begin epa = 1; epb = 1; end
			default: case (d[11:9])
				3'h1: begin qa = ea; epa = 0; end
				3'h5: begin qb = eb; epb = 0; end
				3'h6: if (lock_n) epa = 1;
				3'h7: if (lock_n) epb = 1;
				3'h2: eupo = 0;
				3'h3: eupo = 1;
				3'h4: emode = d[8];
				default: ;
			endcase
		endcase
	endfunction

	// Send one frame, let the commit cross (3..5 cycles), then compare.
	task automatic do_word(input logic [15:0] wd, input int pre);
		host_link_model_i.send(wd, pre, rx);
		predict(wd);
		repeat (8) @(negedge clk_sys_i);
		check_all();
	endtask

	// Lockout falling edge wakes both channels.
	task automatic set_lock(input logic v);
		@(negedge clk_sys_i);
		if (lock_n && !v) begin
			epa = 1'h0;
			epb = 1'h0;
		end
		lock_n = v;
		repeat (8) @(negedge clk_sys_i);
		check_all();
	endtask

	initial begin
		nrst_i = 1'h0; clear_n_i = 1'h1; lock_n = 1'h1;
		rst_exp();
		repeat (4) @(negedge clk_sys_i);
		nrst_i = 1'h1;
		@(negedge clk_sys_i);
		check_all();
		// Readback: the second frame shifts out the first word whole.
		do_word({3'h5, 12'hA5C, 1'h0}, 0);
		do_word({3'h1, 12'h3C7, 1'h0}, 0);
		cmp16(rx, {3'h5, 12'hA5C, 1'h0}, "data out");
		// Every header, then every extended code with both last-bit values.
		for (int h = 1; h < 8; h++) begin
			r = $random(seed);
			do_word({h[2:0], r[11:0], 1'h0}, 0);
		end
		for (int c = 0; c < 16; c++) begin
			r = $random(seed);
			do_word({3'h0, c[3:0], r[7:0], 1'h0}, 0);
		end
		// Code 1001 left the rising-edge output mode on: read back through it.
		do_word({3'h1, 12'h5A3, 1'h0}, 0);
		do_word({3'h5, 12'h1E8, 1'h0}, 0);
		cmp16(rx, {3'h1, 12'h5A3, 1'h0}, "data out rising");
		// Shutdowns refused with lockout low, then lockout edge wakes.
		set_lock(1'h0);
		do_word({3'h7, 12'hFFF, 1'h0}, 0);
		do_word({3'h0, 12'hC00, 1'h0}, 0);
		do_word({3'h0, 12'hE00, 1'h0}, 0);
		set_lock(1'h1);
		do_word({3'h7, 12'h000, 1'h0}, 0);
		set_lock(1'h0);
		set_lock(1'h1);
		// Random traffic with stray leading clocks and lockout changes.
		for (int i = 0; i < 70; i++) begin
			r = $random(seed);
			w = {r[15:1], 1'h0};
			if (r[20:18] == 3'h0)
				set_lock(~lock_n);
			do_word(w, (r[23:22] == 2'h0) ? int'(r[25:24]) + 1 : 0);
		end
		// Clear at the end of the run, then a final check.
		@(negedge clk_sys_i);
		clear_n_i = 1'h0;
		rst_exp();
		@(negedge clk_sys_i);
		clear_n_i = 1'h1;
		@(negedge clk_sys_i);
		check_all();
		stop_test();
	end
endmodule // testbench
